// File: logic/srsc_cfg.svh
// Constants for the serial receive status and control block
`ifndef SRSC_CFG_SVH
`define SRSC_CFG_SVH
`define SRSC_CLK_HZ        40000000
`define SRSC_BAUD_HZ       115200
`define SRSC_BIT_CYCLES    (`SRSC_CLK_HZ / `SRSC_BAUD_HZ)
`define SRSC_HALF_CYCLES   (`SRSC_BIT_CYCLES / 2)
`define SRSC_CNT_W         16
`define SRSC_WORD_W        9
`define SRSC_FIFO_W        10
`define SRSC_FIFO_DEPTH    32
`define SRSC_FIFO_AW       5
`define SRSC_NINTH_POS     8
`define SRSC_FRAME_ERR_POS 9
`endif

// File: logic/srsc_fifo.sv
// Parameterised receive FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module srsc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  // Fill side
  srsc_fifo_if.snk              wr,
  // Drain side
  output logic [WIDTH-1:0]      rd_data_o,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  wire              empty = (wptr == rptr);
  wire              full  = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire              pop   = rd_ready_i || !rd_valid_o;
  wire              do_rd = pop && !empty;
  wire              do_wr = wr.valid && !full;
  assign wr.ready = !full;
  always_ff @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem[wptr[AW-1:0]] <= wr.data;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr       <= '0;
      rptr       <= '0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
    end else if (flush_i) begin
      wptr       <= '0;
      rptr       <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      if (do_wr) wptr <= wptr + 1'b1;
      if (do_rd) begin
        rptr      <= rptr + 1'b1;
        rd_data_o <= mem[rptr[AW-1:0]];
      end
      if (pop) rd_valid_o <= !empty;
    end
  end
endmodule // srsc_fifo
`default_nettype wire

// File: logic/srsc_fifo_if.sv
// Valid/ready carrier between receiver and buffer
`timescale 1ns/1ps
`default_nettype none
interface srsc_fifo_if;
  logic [9:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// File: logic/srsc_pkg.sv
// Types for the serial receive status and control block
`default_nettype none
package srsc_pkg;
  typedef enum logic [1:0] {
    SRSC_IDLE,
    SRSC_START,
    SRSC_DATA,
    SRSC_STOP
  } srsc_state_type;
  typedef logic [9:0] srsc_entry_type;
endpackage
`default_nettype wire

// File: logic/srsc_rx.sv
// Receive control and status logic of the serial port
`timescale 1ns/1ps
`default_nettype none
`include "srsc_cfg.svh"
//Contract
// - In synchronous mode continuous receive runs until cleared, overrides single receive, and stops when cleared.
// - Async 9-bit with address detect loads the buffer and interrupts only for words with ninth bit set.
// - Async 9-bit without address detect accepts every word and keeps its ninth bit.
// - Async 8-bit ignores address detect; software keeps it zero in synchronous mode.
// - Framing flag follows the word read from the data register, set on error and clear otherwise.
// - Overrun flag sets on overrun and clears only when continuous receive is cleared.
// - The ninth bit of each 9-bit word is stored for software.
module srsc_rx (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  // Serial pins
  input  wire logic                 rx_pin_i,
  input  wire logic                 sync_clk_pin_i,
  // Control
  input  wire logic                 sync_mode_i,
  input  wire logic                 continuous_receive_enable_i,
  input  wire logic                 single_receive_enable_i,
  input  wire logic                 address_detect_enable_i,
  input  wire logic                 nine_bit_receive_select_i,
  input  wire logic                 receive_data_read_i,
  // Status and data
  output logic [7:0]                receive_data_register_o,
  output logic                      received_ninth_bit_o,
  output logic                      framing_error_flag_o,
  output logic                      overrun_error_flag_o,
  output logic                      receive_interrupt_o,
  output logic                      single_receive_done_o
);
  import srsc_pkg::*;
  srsc_state_type             state;
  srsc_state_type             next_state;
  logic [1:0]                 rx_sync;
  logic [1:0]                 ck_sync;
  logic                       ck_prev;
  logic [`SRSC_CNT_W-1:0]     cnt;
  logic [3:0]                 bit_idx;
  logic [8:0]                 receive_shift_register;
  logic                       word_done;
  logic                       word_frame_err;
  logic                       single_busy;
  logic                       fifo_rd_valid;
  srsc_entry_type             fifo_rd_data;
  srsc_fifo_if                wr_if ();
  wire rx_s       = rx_sync[1];
  wire ck_rise    = ck_sync[1] && !ck_prev;
  wire sync_run   = continuous_receive_enable_i || single_busy;
  wire async_run  = continuous_receive_enable_i;
  wire run        = sync_mode_i ? sync_run : async_run;
  wire [3:0] last_idx = nine_bit_receive_select_i ? 4'h8 : 4'h7;
  wire bit_tick   = (cnt == `SRSC_CNT_W'(`SRSC_BIT_CYCLES - 1));
  wire half_tick  = (cnt == `SRSC_CNT_W'(`SRSC_HALF_CYCLES - 1));
  // Address detect counts only in async 9-bit mode
  wire addr_gate  = !sync_mode_i && nine_bit_receive_select_i
                    && address_detect_enable_i;
  wire ninth_in   = nine_bit_receive_select_i && receive_shift_register[8];
  wire word_keep  = !addr_gate || ninth_in;
  wire push       = word_done && word_keep;
  wire overrun    = push && !wr_if.ready;
  // Reading while the FIFO holds data shows the next word
  wire load_out   = fifo_rd_valid && (receive_data_read_i || !receive_interrupt_o);
  assign wr_if.data  = {word_frame_err, ninth_in, receive_shift_register[7:0]};
  assign wr_if.valid = push && !overrun_error_flag_o; // Overrun freezes intake
  always_comb begin
    next_state = state;
    unique case (state)
      SRSC_IDLE:  if (run && (sync_mode_i ? 1'b1 : !rx_s)) begin
                    next_state = sync_mode_i ? SRSC_DATA : SRSC_START;
                  end
      SRSC_START: if (half_tick) begin
                    next_state = rx_s ? SRSC_IDLE : SRSC_DATA;
                  end
      SRSC_DATA:  if ((sync_mode_i ? ck_rise : bit_tick) && bit_idx == last_idx) begin
                    next_state = sync_mode_i ? SRSC_IDLE : SRSC_STOP;
                  end
      SRSC_STOP:  if (bit_tick) begin
                    next_state = SRSC_IDLE;
                  end
    endcase
    if (!run) next_state = SRSC_IDLE;
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sync <= 2'b11;
      ck_sync <= 2'b00;
      ck_prev <= 1'b0;
    end else begin
      rx_sync <= {rx_sync[0], rx_pin_i};
      ck_sync <= {ck_sync[0], sync_clk_pin_i};
      ck_prev <= ck_sync[1];
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state                  <= SRSC_IDLE;
      cnt                    <= '0;
      bit_idx                <= '0;
      receive_shift_register <= '0;
      word_done              <= 1'b0;
      word_frame_err         <= 1'b0;
    end else begin
      state     <= next_state;
      word_done <= 1'b0;
      cnt       <= (state == SRSC_IDLE || half_tick && state == SRSC_START || bit_tick)
                   ? '0 : cnt + 1'b1;
      if (state == SRSC_IDLE) begin
        bit_idx                <= '0;
        receive_shift_register <= '0;
      end
      if (state == SRSC_DATA && (sync_mode_i ? ck_rise : bit_tick)) begin
        receive_shift_register[bit_idx] <= rx_s;
        bit_idx                         <= bit_idx + 1'b1;
        if (sync_mode_i && bit_idx == last_idx) begin
          word_done <= 1'b1;
          word_frame_err <= 1'b0;
        end
      end
      if (state == SRSC_STOP && bit_tick) begin
        word_done <= 1'b1;
        word_frame_err <= !rx_s;
      end
    end
  end
  // Single receive ends after one word; continuous receive takes precedence
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      single_busy           <= 1'b0;
      single_receive_done_o <= 1'b0;
    end else begin
      single_receive_done_o <= single_busy && word_done && !continuous_receive_enable_i;
      // Continuous receive overrides, so no single request outlives it
      if (continuous_receive_enable_i || word_done) single_busy <= 1'b0;
      else if (sync_mode_i && single_receive_enable_i) single_busy <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overrun_error_flag_o <= 1'b0;
    end else if (overrun) begin
      overrun_error_flag_o <= 1'b1; // set wins over clear
    end else if (!continuous_receive_enable_i) begin
      overrun_error_flag_o <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      receive_data_register_o <= '0;
      received_ninth_bit_o    <= 1'b0;
      framing_error_flag_o    <= 1'b0;
      receive_interrupt_o     <= 1'b0;
    end else if (load_out) begin
      receive_data_register_o <= fifo_rd_data[7:0];
      received_ninth_bit_o    <= fifo_rd_data[`SRSC_NINTH_POS];
      framing_error_flag_o    <= fifo_rd_data[`SRSC_FRAME_ERR_POS];
      receive_interrupt_o     <= 1'b1;
    end else if (receive_data_read_i) begin
      receive_interrupt_o     <= 1'b0;
    end
  end
  srsc_fifo #(
    .WIDTH (`SRSC_FIFO_W),
    .DEPTH (`SRSC_FIFO_DEPTH),
    .AW    (`SRSC_FIFO_AW)
  ) u_fifo (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .flush_i    (1'b0),
    .wr         (wr_if),
    .rd_data_o  (fifo_rd_data),
    .rd_valid_o (fifo_rd_valid),
    .rd_ready_i (load_out)
  );
endmodule // srsc_rx
`default_nettype wire

// File: test/srsc_rx_chk.sv
// Port assertions for the receive block
`timescale 1ns/1ps
`default_nettype none
module srsc_rx_chk (
  // Clock and control
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       sync_mode_i,
  input wire logic       continuous_receive_enable_i,
  input wire logic       address_detect_enable_i,
  input wire logic       nine_bit_receive_select_i,
  input wire logic       receive_data_read_i,
  // Status
  input wire logic [7:0] receive_data_register_o,
  input wire logic       received_ninth_bit_o,
  input wire logic       framing_error_flag_o,
  input wire logic       overrun_error_flag_o,
  input wire logic       receive_interrupt_o,
  input wire logic       single_receive_done_o
);
  wire cont_en = continuous_receive_enable_i;
  wire irq  = receive_interrupt_o;
  wire rd   = receive_data_read_i;
  wire ovr  = overrun_error_flag_o;
  wire n9   = received_ninth_bit_o;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence shown_s; $rose(irq); endsequence
  // Read needs a cycle to advance, so skip the cycle after one
  sequence quiet_s; irq && !rd && !$past(rd); endsequence
  addr_filter_a: assert property (shown_s ##0 (!sync_mode_i && nine_bit_receive_select_i && address_detect_enable_i) |-> n9) else $error("word without ninth bit shown");
  eight_ninth_a: assert property (shown_s ##0 !nine_bit_receive_select_i |-> !n9) else $error("ninth bit set in 8-bit mode");
  irq_stands_a: assert property (irq && !rd |=> irq) else $error("interrupt dropped without read");
  data_stands_a: assert property (quiet_s |=> $stable(receive_data_register_o) && $stable(n9)) else $error("shown word changed");
  frame_stands_a: assert property (quiet_s |=> $stable(framing_error_flag_o)) else $error("framing flag changed unread");
  sync_framing_error_flag_a: assert property (shown_s ##0 sync_mode_i |-> !framing_error_flag_o) else $error("framing flag in sync mode");
  ovr_sticky_a: assert property (ovr && cont_en && $past(cont_en) |=> ovr) else $error("overrun cleared while enabled");
  ovr_clear_a: assert property (!cont_en && !sync_mode_i |=> !ovr) else $error("overrun not cleared");
  done_pulse_a: assert property (single_receive_done_o |=> !single_receive_done_o) else $error("done longer than a cycle");
endmodule // srsc_rx_chk
bind srsc_rx srsc_rx_chk chk_u (
  .sys_clk_i                   (sys_clk_i),
  .rst_n_i                     (rst_n_i),
  .sync_mode_i                 (sync_mode_i),
  .continuous_receive_enable_i (continuous_receive_enable_i),
  .address_detect_enable_i     (address_detect_enable_i),
  .nine_bit_receive_select_i   (nine_bit_receive_select_i),
  .receive_data_read_i         (receive_data_read_i),
  .receive_data_register_o     (receive_data_register_o),
  .received_ninth_bit_o        (received_ninth_bit_o),
  .framing_error_flag_o        (framing_error_flag_o),
  .overrun_error_flag_o        (overrun_error_flag_o),
  .receive_interrupt_o         (receive_interrupt_o),
  .single_receive_done_o       (single_receive_done_o)
);
`default_nettype wire

// File: test/srsc_rx_tb.sv
// Self-checking bench for the receive block
`timescale 1ns/1ps
`default_nettype none
module srsc_rx_tb;
  logic clk = 0, rst_n = 0, sync = 0, cont_en = 0;
  logic single_en = 0, addr_en = 0, nine = 0, rd = 0;
  logic rx, sck, ninth, frame_err, ovr, irq, done;
  logic [7:0] dat;
  int n_mismatch = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  srsc_tx_model tx_u (.sys_clk_i(clk), .rx_o(rx), .sck_o(sck));
  srsc_rx dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .rx_pin_i(rx), .sync_clk_pin_i(sck),
    .sync_mode_i(sync), .continuous_receive_enable_i(cont_en),
    .single_receive_enable_i(single_en), .address_detect_enable_i(addr_en),
    .nine_bit_receive_select_i(nine), .receive_data_read_i(rd),
    .receive_data_register_o(dat), .received_ninth_bit_o(ninth),
    .framing_error_flag_o(frame_err), .overrun_error_flag_o(ovr), .receive_interrupt_o(irq),
    .single_receive_done_o(done));
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string s, input logic [8:0] e, input logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // Wait for a shown word, judge it, then read it away
  task automatic got(input logic [8:0] e, input logic fe);
    int k;
    k = 0;
    @(negedge clk);
    while (irq !== 1'h1 && k < 500) begin
      @(negedge clk);
      k++;
    end
    if (k == 500) begin
      n_mismatch++;
      close_out();
    end
    chk("word", e, {ninth, dat});
    chk("framing", {8'h00, fe}, {8'h00, frame_err});
    @(posedge clk) rd <= 1'h1;
    @(posedge clk) rd <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic quiet();
    repeat (50) @(negedge clk);
    chk("interrupt", 9'h000, {8'h00, irq});
  endtask
  task automatic t_async();
    cont_en <= 1'h1;
    addr_en <= 1'h1;
    @(posedge clk);
    tx_u.async_send(9'h05A, 1'h0, 1'h1); got(9'h05A, 1'h0);
    tx_u.async_send(9'h03C, 1'h0, 1'h0); got(9'h03C, 1'h1);
    tx_u.async_send(9'h0C3, 1'h0, 1'h1); got(9'h0C3, 1'h0);
    nine <= 1'h1;
    @(posedge clk);
    tx_u.async_send(9'h1A5, 1'h1, 1'h1); got(9'h1A5, 1'h0);
    tx_u.async_send(9'h033, 1'h1, 1'h1); quiet();
    tx_u.async_send(9'h1C3, 1'h1, 1'h1); got(9'h1C3, 1'h0);
    addr_en <= 1'h0;
    @(posedge clk);
    tx_u.async_send(9'h0F0, 1'h1, 1'h1); got(9'h0F0, 1'h0);
    tx_u.async_send(9'h10F, 1'h1, 1'h1); got(9'h10F, 1'h0);
    $display("t_async done");
  endtask
  // Overfill the buffer, drain it, then clear the enable
  task automatic t_sync();
    int n_done;
    n_done = 0;
    sync <= 1'h1;
    nine <= 1'h0;
    addr_en <= 1'h0;
    single_en <= 1'h1;
    @(posedge clk);
    for (int i = 0; i < 36; i++) tx_u.sync_send(8'h40 + 8'(i));
    chk("overrun", 9'h001, {8'h00, ovr});
    // Shown word and buffer read stage sit ahead of the 32 stored words
    for (int i = 0; i < 34; i++) got(9'h040 + 9'(i), 1'h0);
    chk("interrupt", 9'h000, {8'h00, irq});
    cont_en <= 1'h0;
    single_en <= 1'h0;
    repeat (3) @(posedge clk);
    chk("overrun", 9'h000, {8'h00, ovr});
    tx_u.sync_send(8'h77); quiet();
    single_en <= 1'h1;
    @(posedge clk);
    @(posedge clk) single_en <= 1'h0;
    fork
      tx_u.sync_send(8'hA9);
      for (int k = 0; k < 100; k++) begin
        @(negedge clk);
        if (done === 1'h1) n_done++;
      end
    join
    chk("done", 9'h001, 9'(n_done));
    got(9'h0A9, 1'h0);
    tx_u.sync_send(8'h5C); quiet();
    $display("t_sync done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    t_async();
    t_sync();
    close_out();
  end
endmodule // srsc_rx_tb
`default_nettype wire

// File: test/srsc_tx_model.sv
// Remote transmitter model driving the receive pins
`timescale 1ns/1ps
`default_nettype none
`include "srsc_cfg.svh"
module srsc_tx_model (
  // Clock
  input  wire logic sys_clk_i,
  // Serial pins
  output var logic  rx_o,
  output var logic  sck_o
);
  initial begin
    rx_o = 1'h1;
    sck_o = 1'h0;
  end
  // Start low, data LSB first, stop as commanded, then idle high
  task automatic async_send(input logic [8:0] w, input logic n9, input logic stop);
    logic [11:0] f;
    f = n9 ? {1'h1, stop, w, 1'h0} : {2'h3, stop, w[7:0], 1'h0};
    for (int i = 0; i < 12; i++) begin
      rx_o <= f[i];
      repeat (`SRSC_BIT_CYCLES) @(posedge sys_clk_i);
    end
  endtask
  // Bit clock idles low; data settles well before each rise
  task automatic sync_send(input logic [7:0] w);
    for (int i = 0; i < 8; i++) begin
      rx_o <= w[i];
      repeat (4) @(posedge sys_clk_i);
      sck_o <= 1'h1;
      repeat (4) @(posedge sys_clk_i);
      sck_o <= 1'h0;
    end
    rx_o <= ~w[7];
    repeat (4) @(posedge sys_clk_i);
  endtask
endmodule // srsc_tx_model
`default_nettype wire
